// ===== rtl/sensor_drive_io_pkg.sv
// Constants for the two-pin sensor drive port.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package sensor_drive_io_pkg;

  // Byte addresses of the registers
  localparam logic [7:0] port_output_control_addr = 8'h00;
  localparam logic [7:0] port_input_levels_addr = 8'h04;
  localparam logic [7:0] chip_mode_control_addr = 8'h08;

  // Field positions in the output control register
  localparam int data_a_bit = 1;
  localparam int data_b_bit = 2;
  localparam int dir_a_bit = 4;
  localparam int dir_b_bit = 5;

  // Field positions in the input levels register
  localparam int level_a_bit = 0;
  localparam int level_b_bit = 1;

  // Field positions in the mode control register
  localparam int ref_out_a_bit = 0;
  localparam int ref_in_b_bit = 1;

  // Values after reset
  localparam logic [1:0] data_reset = 2'h0;
  localparam logic [1:0] dir_reset = 2'h3;
  localparam logic [1:0] mode_reset = 2'h0;
  localparam logic [1:0] sync_reset = 2'h0;
  localparam logic pin_reset = 1'b0;
  localparam logic [31:0] rdata_reset = 32'h00000000;

endpackage

// ===== rtl/sensor_drive_io_port.sv
// Two-pin general purpose port used to drive or bias sensor elements,
// reached by software over APB.
// Assumes the pad ring resolves pin level from the output enables, and
// that analog reference switching is done by the pad from the mode outputs.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module sensor_drive_io_port (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pin a
  input wire logic sensor_drive_pin_a_in,
  output logic sensor_drive_pin_a_out,
  output logic sensor_drive_pin_a_oe,
  // Pin b
  input wire logic sensor_drive_pin_b_in,
  output logic sensor_drive_pin_b_out,
  output logic sensor_drive_pin_b_oe,
  // Analog switch controls for the pads
  output logic reference_out_on_pin_a,
  output logic reference_in_on_pin_b
);

  // Stored register fields, one bit per pin: [0] pin a, [1] pin b
  logic [1:0] data_bits;
  logic [1:0] dir_bits;
  logic [1:0] mode_bits;
  logic [1:0] next_data_bits;
  logic [1:0] next_dir_bits;
  logic [1:0] next_mode_bits;

  // Pin level synchroniser stages
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;

  // Pin drive terms ahead of their output flip-flops
  logic [1:0] ref_active;
  logic [1:0] next_drive_en;
  logic [1:0] next_drive_val;

  // Bus decode
  logic access;
  logic wr_lane0;
  logic rd_setup;
  logic upper_zero;
  logic sel_out_ctl;
  logic sel_in_lvl;
  logic sel_mode;
  logic addr_ok;
  logic wr_out_ctl;
  logic wr_mode;

  // Read words of the three registers and the one selected
  logic [31:0] read_out_ctl;
  logic [31:0] read_in_lvl;
  logic [31:0] read_mode;
  logic [31:0] next_prdata;

  // Register map, one 32-bit word each, unused bits read as zero:
  //   0x00 output control: bit 1 data a, bit 2 data b,
  //        bit 4 direction a, bit 5 direction b
  //   0x04 input levels: bit 0 pin a, bit 1 pin b, read only
  //   0x08 mode control: bit 0 reference out on pin a,
  //        bit 1 reference in on pin b
  // Writes to the input levels word are dropped without an error.
  // Any other address answers with an error and changes nothing.

  // Transfer timing, counted in rising edges:
  //   setup edge: read data is loaded from the selected word
  //   access edge: a write lands in its register, the transfer ends
  //   next edge: output enables and levels follow the new fields
  // Back-to-back transfers need no idle cycle between them.
  // A pin change passes two edges of synchroniser before a setup edge
  // can load it into read data.

  // Limitations:
  //   only byte lane 0 carries fields, so a write without it is lost
  //   with the clock enable low nothing is taken while pready stays
  //   high, so a master must not start a transfer while frozen
  //   the error flag stands in the access phase only, never in setup
  //   the reference switching itself is analog and lives in the pad

  // Zero wait states; the access phase ends as soon as it starts.
  // A slave that never stalls keeps the master simple, at the cost of
  // loading read data one cycle early, in the setup phase.
  assign pready = 1'b1;

  // A transfer counts only while the clock enable is high
  assign access = psel & penable & clk_en;
  assign wr_lane0 = access & pwrite & pstrb[0];
  assign rd_setup = clk_en & psel & ~penable & ~pwrite;

  // Address decode; the low byte selects, the rest must be zero
  assign upper_zero = (paddr[31:8] == 24'h000000);
  always_comb begin
    sel_out_ctl = 1'b0;
    sel_in_lvl = 1'b0;
    sel_mode = 1'b0;
    case (paddr[7:0])
      sensor_drive_io_pkg::port_output_control_addr: sel_out_ctl = 1'b1;
      sensor_drive_io_pkg::port_input_levels_addr: sel_in_lvl = 1'b1;
      sensor_drive_io_pkg::chip_mode_control_addr: sel_mode = 1'b1;
      default: sel_out_ctl = 1'b0;
    endcase
  end
  assign addr_ok = upper_zero & (sel_out_ctl | sel_in_lvl | sel_mode);

  // Unmapped access errors in the access phase only
  assign pslverr = psel & penable & ~addr_ok;

  // Write strobes per register; input levels has none at all
  assign wr_out_ctl = wr_lane0 & addr_ok & sel_out_ctl;
  assign wr_mode = wr_lane0 & addr_ok & sel_mode;

  // Next data bits. They are written whatever the direction, so a value
  // loaded while a pin is input only or in reference mode is driven
  // once digital output returns.
  always_comb begin
    next_data_bits = data_bits;
    if (wr_out_ctl) begin
      next_data_bits[0] = pwdata[sensor_drive_io_pkg::data_a_bit];
      next_data_bits[1] = pwdata[sensor_drive_io_pkg::data_b_bit];
    end
  end

  // Next direction bits, one per pin
  always_comb begin
    next_dir_bits = dir_bits;
    if (wr_out_ctl) begin
      next_dir_bits[0] = pwdata[sensor_drive_io_pkg::dir_a_bit];
      next_dir_bits[1] = pwdata[sensor_drive_io_pkg::dir_b_bit];
    end
  end

  // Next mode control fields
  always_comb begin
    next_mode_bits = mode_bits;
    if (wr_mode) begin
      next_mode_bits[0] = pwdata[sensor_drive_io_pkg::ref_out_a_bit];
      next_mode_bits[1] = pwdata[sensor_drive_io_pkg::ref_in_b_bit];
    end
  end

  // Stored data bits; cleared at reset so a pin first drives low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_bits <= sensor_drive_io_pkg::data_reset;
    end else if (clk_en) begin
      data_bits <= next_data_bits;
    end
  end

  // Direction bits; set at reset so every pin starts as output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_bits <= sensor_drive_io_pkg::dir_reset;
    end else if (clk_en) begin
      dir_bits <= next_dir_bits;
    end
  end

  // Mode bits for reference routing; digital function after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_bits <= sensor_drive_io_pkg::mode_reset;
    end else if (clk_en) begin
      mode_bits <= next_mode_bits;
    end
  end

  // Pins come from outside the clock domain, so two flip-flops stand
  // before any logic. No debounce: a glitch that lands on an edge is
  // reported as it is, and filtering is left to the board.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= sensor_drive_io_pkg::sync_reset;
    end else if (clk_en) begin
      pin_meta <= {sensor_drive_pin_b_in, sensor_drive_pin_a_in};
    end
  end

  // Second stage; the only reader of the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync <= sensor_drive_io_pkg::sync_reset;
    end else if (clk_en) begin
      pin_sync <= pin_meta;
    end
  end

  // Reference mode wins over the digital function of its pin.
  // The input side is never switched off, so a driven pin still reads
  // back the level that really stands on it. Stored data is untouched
  // here, so it returns when output resumes.
  assign ref_active = mode_bits;
  always_comb begin
    next_drive_en = dir_bits & ~ref_active;
    next_drive_val = data_bits;
  end

  // Output enables; registered so the pads see no decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sensor_drive_pin_a_oe <= sensor_drive_io_pkg::pin_reset;
      sensor_drive_pin_b_oe <= sensor_drive_io_pkg::pin_reset;
    end else if (clk_en) begin
      sensor_drive_pin_a_oe <= next_drive_en[0];
      sensor_drive_pin_b_oe <= next_drive_en[1];
    end
  end

  // Driven levels follow the stored data even while the driver is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sensor_drive_pin_a_out <= sensor_drive_io_pkg::pin_reset;
      sensor_drive_pin_b_out <= sensor_drive_io_pkg::pin_reset;
    end else if (clk_en) begin
      sensor_drive_pin_a_out <= next_drive_val[0];
      sensor_drive_pin_b_out <= next_drive_val[1];
    end
  end

  // Analog switch controls; high hands the pin to the reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_out_on_pin_a <= sensor_drive_io_pkg::pin_reset;
      reference_in_on_pin_b <= sensor_drive_io_pkg::pin_reset;
    end else if (clk_en) begin
      reference_out_on_pin_a <= ref_active[0];
      reference_in_on_pin_b <= ref_active[1];
    end
  end

  // Output control word; every bit outside a field reads as zero
  always_comb begin
    read_out_ctl = 32'h00000000;
    read_out_ctl[sensor_drive_io_pkg::data_a_bit] = data_bits[0];
    read_out_ctl[sensor_drive_io_pkg::data_b_bit] = data_bits[1];
    read_out_ctl[sensor_drive_io_pkg::dir_a_bit] = dir_bits[0];
    read_out_ctl[sensor_drive_io_pkg::dir_b_bit] = dir_bits[1];
  end

  // Input levels come from the second synchroniser stage only.
  // The register has no write path, so a write to it is simply lost.
  always_comb begin
    read_in_lvl = 32'h00000000;
    read_in_lvl[sensor_drive_io_pkg::level_a_bit] = pin_sync[0];
    read_in_lvl[sensor_drive_io_pkg::level_b_bit] = pin_sync[1];
  end

  // Mode control word
  always_comb begin
    read_mode = 32'h00000000;
    read_mode[sensor_drive_io_pkg::ref_out_a_bit] = mode_bits[0];
    read_mode[sensor_drive_io_pkg::ref_in_b_bit] = mode_bits[1];
  end

  // Read mux; an unmapped address reads zero alongside its error
  always_comb begin
    next_prdata = 32'h00000000;
    if (addr_ok && sel_out_ctl) begin
      next_prdata = read_out_ctl;
    end else if (addr_ok && sel_in_lvl) begin
      next_prdata = read_in_lvl;
    end else if (addr_ok && sel_mode) begin
      next_prdata = read_mode;
    end
  end

  // Read data is loaded in the setup cycle, so it already stands when the
  // zero-wait access phase samples it; it then holds until the next read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= sensor_drive_io_pkg::rdata_reset;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

endmodule

`default_nettype wire

// ===== tb/sensor_drive_io_monitor.sv
// Port checker for the two-pin sensor drive port.
// Assumes one clock domain; bound to the port's top module.
`timescale 1ns/1ps
`default_nettype none
module sensor_drive_io_monitor (
  // Watched ports
  input wire logic pclk, presetn, clk_en, psel, penable, pwrite,
  input wire logic [31:0] paddr, pwdata, prdata,
  input wire logic [3:0] pstrb,
  input wire logic sensor_drive_pin_a_in, sensor_drive_pin_a_out,
  input wire logic sensor_drive_pin_a_oe, sensor_drive_pin_b_oe,
  input wire logic sensor_drive_pin_b_out,
  input wire logic reference_out_on_pin_a, reference_in_on_pin_b
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write to output control taken at this edge
  wire logic wr = psel && penable && pwrite && clk_en && pstrb[0]
    && paddr == 32'h0;
  data_a_out_a: assert property (wr ##1 clk_en |=>
    sensor_drive_pin_a_out == $past(pwdata[1], 2)) else $error("data a");
  data_b_out_a: assert property (wr ##1 clk_en |=>
    sensor_drive_pin_b_out == $past(pwdata[2], 2)) else $error("data b");
  dir_a_oe_a: assert property (wr ##1 clk_en |=>
    sensor_drive_pin_a_oe == ($past(pwdata[4], 2) &&
    !reference_out_on_pin_a)) else $error("dir a");
  ref_a_off_a: assert property (reference_out_on_pin_a |->
    !sensor_drive_pin_a_oe) else $error("ref a drives");
  ref_b_off_a: assert property (reference_in_on_pin_b |->
    !sensor_drive_pin_b_oe) else $error("ref b drives");
  reset_dir_a: assert property ($rose(presetn) && clk_en |=>
    sensor_drive_pin_a_oe && sensor_drive_pin_b_oe) else $error("rst");
  level_read_a: assert property (psel && !penable && !pwrite &&
    clk_en && paddr == 32'h4 |=> prdata[0] == $past(sensor_drive_pin_a_in,
    3)) else $error("level a");
  data_kept_a: assert property (!wr |-> ##2
    $stable(sensor_drive_pin_a_out)) else $error("data a moved");
endmodule
bind sensor_drive_io_port sensor_drive_io_monitor i_mon (.*);
`default_nettype wire

// ===== tb/sensor_load.sv
// Sensor elements hung on the two port pins.
// Assumes oe high means the port drives the pin.
`timescale 1ns/1ps
`default_nettype none
module sensor_load (
  // Port side and sensor side
  input wire logic a_out, a_oe, b_out, b_oe, a_ext, b_ext,
  output logic a_lvl, b_lvl
);
  // A released pin shows the sensor's own level, not the stale drive
  assign a_lvl = a_oe ? a_out : a_ext;
  assign b_lvl = b_oe ? b_out : b_ext;
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Bench for the sensor drive port: APB tasks and pin scenarios.
// Assumes a zero-wait APB slave and two-flop pin synchronisers.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
  logic pwrite = 0, a_ext = 0, b_ext = 0, ao, aoe, bo, boe, pa, pb;
  logic err, pready, pslverr, ra, rb;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic [3:0] strb = 4'hf;
  int n_fail = 0, total_checks = 0, cyc = 0;
  sensor_drive_io_port i_sensor_drive_io_port (.pclk, .presetn, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(strb), .prdata,
    .pready, .pslverr, .sensor_drive_pin_a_in(pa),
    .sensor_drive_pin_a_out(ao), .sensor_drive_pin_a_oe(aoe),
    .sensor_drive_pin_b_in(pb), .sensor_drive_pin_b_out(bo),
    .sensor_drive_pin_b_oe(boe), .reference_out_on_pin_a(ra),
    .reference_in_on_pin_b(rb));
  sensor_load i_sensor_load (.a_out(ao), .a_oe(aoe), .b_out(bo),
    .b_oe(boe), .a_ext, .b_ext, .a_lvl(pa), .b_lvl(pb));
  initial forever #20 pclk = ~pclk;
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(logic w, logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Pins lag the write by one edge
  task automatic wr(logic [31:0] a, d);
    apb(1, a, d);
    @(posedge pclk);
    #1;
  endtask
  // Let pin levels pass the synchronisers first
  task automatic rd(logic [31:0] a);
    repeat (3) @(posedge pclk);
    apb(0, a, 0);
  endtask
  task automatic t_pins();
    rd(0);
    chk("ctl", r, 32'h30);
    wr(0, 32'h36);
    chk("pins", {ao, aoe, bo, boe}, 4'hf);
    rd(4);
    chk("back", r, 32'h3);
    wr(0, 32'h06);
    chk("oe", {aoe, boe}, 2'h0);
    for (int i = 1; i < 3; i++) begin
      @(posedge pclk);
      {b_ext, a_ext} <= 2'(i);
      rd(4);
      chk("lvl", r, 32'(i));
    end
    wr(4, 32'h0);
    rd(4);
    chk("ro", r, 32'h2);
    wr(8, 32'h3);
    wr(0, 32'h36);
    chk("ref", {ra, rb, aoe, boe}, 4'hc);
    wr(8, 32'h0);
    chk("kept", {ao, aoe, bo, boe}, 4'hf);
    rd(32'hc);
    chk("err", {31'h0, err}, 32'h1);
    chk("err data", r, 32'h0);
  endtask
  // Frozen clock enable and a missing byte lane both leave state alone
  task automatic t_hold();
    clk_en <= 0;
    wr(0, 32'h0);
    chk("frozen", {ao, aoe, bo, boe}, 4'hf);
    @(posedge pclk);
    clk_en <= 1;
    strb <= 4'he;
    wr(0, 32'h0);
    @(posedge pclk);
    strb <= 4'hf;
    rd(0);
    chk("lane", r, 32'h36);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_pins();
    t_hold();
    test_done();
  end
endmodule
`default_nettype wire
